// ==== include/strap_pkg.sv ====
// constants and types for the four-level strap decoder
package strap_pkg;

   // comparator outputs, thermometer coded, rising voltage
   typedef struct packed {
      logic above_high;
      logic above_mid;
      logic above_low;
   } cmp_t;

   // levels in rising voltage order
   typedef enum logic [1:0] {
      LVL_ZERO  = 2'h0,
      LVL_RES   = 2'h1,
      LVL_FLOAT = 2'h2,
      LVL_ONE   = 2'h3
   } level_t;

   typedef struct packed {
      logic [7:0] eq_code;
      logic [2:0] deemph_code;
   } chan_cfg_t;

   localparam logic [7:0] EQ_TABLE [16] = '{
      8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h15, 8'h0B, 8'h0F,
      8'h55, 8'h1F, 8'h2F, 8'h3F, 8'hAA, 8'h7F, 8'hBF, 8'hFF};

   localparam logic [2:0] SWING_ZERO   = 3'h0;
   localparam logic [2:0] SWING_FLOAT  = 3'h3;
   localparam logic [2:0] SWING_RES    = 3'h5;
   localparam logic [2:0] SWING_ONE_LO = 3'h4;
   localparam logic [2:0] SWING_ONE_HI = 3'h6;
   localparam logic [2:0] SWING_MIN    = 3'h0;

   localparam logic [2:0] DEM_N_ZERO  = 3'h0;
   localparam logic [2:0] DEM_N_FLOAT = 3'h2;
   localparam logic [2:0] DEM_N_RES   = 3'h3;
   localparam logic [2:0] DEM_N_ONE   = 3'h5;
   localparam logic [2:0] DEM_S_ZERO  = 3'h0;
   localparam logic [2:0] DEM_S_FLOAT = 3'h1;
   localparam logic [2:0] DEM_S_RES   = 3'h1;
   localparam logic [2:0] DEM_S_ONE   = 3'h2;

   localparam logic [1:0] THR_ZERO  = 2'h2;
   localparam logic [1:0] THR_RES   = 2'h1;
   localparam logic [1:0] THR_FLOAT = 2'h0;
   localparam logic [1:0] THR_ONE   = 2'h3;

   // field of the swing configuration byte used in bus modes
   localparam int SWING_REG_LSB = 2;
   localparam int SWING_REG_MSB = 4;

   localparam int SYNC_STAGES = 2;

endpackage : strap_pkg

// ==== src/four_level_strap_decoder.sv ====
// four-level strap decoder for the two-channel repeater configuration
// Functional notes
// RQ1: equalizer level index from two straps per channel selects 8-bit boost code.
// RQ2: swing strap gives swing code; logic one splits on de-emphasis strap.
// RQ3: de-emphasis strap code table depends on whether swing strap is one.
// RQ4: threshold strap gives 2-bit code for both threshold fields.
// RQ5: pin mode forces channel A swing to the lowest level.
// RQ6: bus modes take channel A swing from config byte bits 4:2.
// RQ7: bus mode with swing strap one forces slave address selects to zero.
// RQ8: comparators at 0.2, 0.5, 0.8 classify pins as 0, R, Float, 1.
// RQ9: board ties bus-enable high for bus, floats for eeprom, low for pins.
// RQ10: channels decode independently; codes latched once after reset release. Channel A swing code keeps following the config byte in bus modes.
`timescale 1ns/1ps
`default_nettype none
module four_level_strap_decoder
   import strap_pkg::*;
(
   input  wire logic       CLOCK_I,
   input  wire logic       RST_B_I,
   input  wire cmp_t       EQ_A_HIGH_I,
   input  wire cmp_t       EQ_A_LOW_I,
   input  wire cmp_t       EQ_B_HIGH_I,
   input  wire cmp_t       EQ_B_LOW_I,
   input  wire cmp_t       DEEMPH_A_I,
   input  wire cmp_t       DEEMPH_B_I,
   input  wire cmp_t       SWING_SELECT_I,
   input  wire cmp_t       DETECT_THRESHOLD_I,
   input  wire cmp_t       BUS_ENABLE_I,
   input  wire logic [3:0] SLAVE_ADDR_SELECT_I,
   input  wire logic [7:0] SWING_CFG_REG_I,
   output logic [7:0]      EQ_A_CODE_O,
   output logic [7:0]      EQ_B_CODE_O,
   output logic [2:0]      DEEMPH_A_CODE_O,
   output logic [2:0]      DEEMPH_B_CODE_O,
   output logic [2:0]      SWING_A_CODE_O,
   output logic [2:0]      SWING_B_CODE_O,
   output logic [3:0]      THRESHOLD_CODE_O,
   output logic [1:0]      BUS_MODE_O,
   output logic [3:0]      SLAVE_ADDR_O,
   output logic            CODES_VALID_O
);

   function automatic logic [2:0] deemph_map(input level_t d, input logic swing_one);
      logic [2:0] r;
      r = DEM_N_ZERO;
      unique case (d)
         LVL_ZERO:  r = swing_one ? DEM_S_ZERO  : DEM_N_ZERO;   // RQ3
         LVL_FLOAT: r = swing_one ? DEM_S_FLOAT : DEM_N_FLOAT;  // RQ3
         LVL_RES:   r = swing_one ? DEM_S_RES   : DEM_N_RES;    // RQ3
         LVL_ONE:   r = swing_one ? DEM_S_ONE   : DEM_N_ONE;    // RQ3
      endcase
      return r;
   endfunction : deemph_map

   // every decoder register lives here; the reset flops stay apart as they own the reset
   typedef struct packed {
      logic                   sampled;
      chan_cfg_t              chan_a;
      chan_cfg_t              chan_b;
      level_t                 swing_lvl;
      level_t                 bus_lvl;
      logic [2:0]             swing_b;
      logic [2:0]             swing_a;
      logic [1:0]             thr;
      logic [3:0]             addr;
   } state_t;

   ////////////////////////////////////////////////////////////////////////
   // reset release
   // release is retimed so every decoder flop leaves reset on the same edge
   logic [SYNC_STAGES-1:0] rst_sync_q;
   logic                   rst_b;

   always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
      if (!RST_B_I) rst_sync_q <= '0;
      else rst_sync_q <= {rst_sync_q[SYNC_STAGES-2:0], 1'b1};
   end
   assign rst_b = rst_sync_q[SYNC_STAGES-1];

   ////////////////////////////////////////////////////////////////////////
   // decode
   state_t     state_q;
   state_t     state_d;
   level_t     eq_a_high_lvl;
   level_t     eq_a_low_lvl;
   level_t     eq_b_high_lvl;
   level_t     eq_b_low_lvl;
   level_t     dem_a_lvl;
   level_t     dem_b_lvl;
   level_t     swing_lvl;
   level_t     thr_lvl;
   level_t     bus_lvl;
   logic       swing_one;
   logic       bus_mode;
   logic [2:0] swing_dec;

   // one classifier per strap pin; pins are judged alone so channels never mix
   strap_level_classifier eq_a_high_cls (
      .cmp_i   (EQ_A_HIGH_I),
      .level_o (eq_a_high_lvl)
   );

   strap_level_classifier eq_a_low_cls (
      .cmp_i   (EQ_A_LOW_I),
      .level_o (eq_a_low_lvl)
   );

   strap_level_classifier eq_b_high_cls (
      .cmp_i   (EQ_B_HIGH_I),
      .level_o (eq_b_high_lvl)
   );

   strap_level_classifier eq_b_low_cls (
      .cmp_i   (EQ_B_LOW_I),
      .level_o (eq_b_low_lvl)
   );

   strap_level_classifier dem_a_cls (
      .cmp_i   (DEEMPH_A_I),
      .level_o (dem_a_lvl)
   );

   strap_level_classifier dem_b_cls (
      .cmp_i   (DEEMPH_B_I),
      .level_o (dem_b_lvl)
   );

   strap_level_classifier swing_cls (
      .cmp_i   (SWING_SELECT_I),
      .level_o (swing_lvl)
   );

   strap_level_classifier thr_cls (
      .cmp_i   (DETECT_THRESHOLD_I),
      .level_o (thr_lvl)
   );

   strap_level_classifier bus_cls (
      .cmp_i   (BUS_ENABLE_I),
      .level_o (bus_lvl)
   );

   always_comb begin
      state_d   = state_q;
      swing_one = (swing_lvl == LVL_ONE);
      swing_dec = SWING_ZERO;
      unique case (swing_lvl)
         LVL_ZERO:  swing_dec = SWING_ZERO;      // RQ2
         LVL_FLOAT: swing_dec = SWING_FLOAT;     // RQ2
         LVL_RES:   swing_dec = SWING_RES;       // RQ2
         // channel B de-emphasis strap steers channel B swing
         LVL_ONE:   swing_dec = (dem_b_lvl == LVL_ZERO || dem_b_lvl == LVL_FLOAT)
                                ? SWING_ONE_LO : SWING_ONE_HI;                     // RQ2
      endcase
      // straps are static; sampling once keeps codes steady against noise
      if (!state_q.sampled) begin
         state_d.sampled            = 1'b1;                                       // RQ10
         state_d.chan_a.eq_code     = EQ_TABLE[{eq_a_high_lvl, eq_a_low_lvl}];   // RQ1
         state_d.chan_b.eq_code     = EQ_TABLE[{eq_b_high_lvl, eq_b_low_lvl}];   // RQ1
         state_d.chan_a.deemph_code = deemph_map(dem_a_lvl, swing_one);           // RQ3
         state_d.chan_b.deemph_code = deemph_map(dem_b_lvl, swing_one);           // RQ3
         state_d.swing_lvl          = swing_lvl;
         state_d.bus_lvl            = bus_lvl;
         state_d.swing_b            = swing_dec;
         unique case (thr_lvl)
            LVL_ZERO:  state_d.thr = THR_ZERO;   // RQ4
            LVL_RES:   state_d.thr = THR_RES;    // RQ4
            LVL_FLOAT: state_d.thr = THR_FLOAT;  // RQ4
            LVL_ONE:   state_d.thr = THR_ONE;    // RQ4
         endcase
      end
      bus_mode = (state_q.bus_lvl != LVL_ZERO);  // RQ9
      // pin mode, or mode not yet known, keeps channel A at the lowest swing
      state_d.swing_a = SWING_MIN;                                            // RQ5
      if (state_q.sampled && bus_mode) begin
         state_d.swing_a = SWING_CFG_REG_I[SWING_REG_MSB:SWING_REG_LSB];   // RQ6
      end
      // address selects follow the pins live so the bus slave sees board changes
      state_d.addr = (state_q.sampled && bus_mode && state_q.swing_lvl == LVL_ONE)
                     ? 4'h0 : SLAVE_ADDR_SELECT_I; // RQ7
   end

   always_ff @(posedge CLOCK_I or negedge rst_b) begin
      if (!rst_b) state_q <= '0;
      else state_q <= state_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign EQ_A_CODE_O      = state_q.chan_a.eq_code;
   assign EQ_B_CODE_O      = state_q.chan_b.eq_code;
   assign DEEMPH_A_CODE_O  = state_q.chan_a.deemph_code;
   assign DEEMPH_B_CODE_O  = state_q.chan_b.deemph_code;
   assign SWING_B_CODE_O   = state_q.swing_b;
   assign THRESHOLD_CODE_O = {state_q.thr, state_q.thr};  // RQ4
   assign BUS_MODE_O       = state_q.bus_lvl;
   assign SLAVE_ADDR_O     = state_q.addr;
   assign CODES_VALID_O    = state_q.sampled;
   // registered: channel A swing lags the config byte by one clock
   assign SWING_A_CODE_O   = state_q.swing_a;  // RQ5

endmodule : four_level_strap_decoder

////////////////////////////////////////////////////////////////////////
// comparator code to strap level
module strap_level_classifier
   import strap_pkg::*;
(
   input  wire cmp_t   cmp_i,
   output var  level_t level_o
);
   always_comb begin
      // thermometer code; a broken code takes the highest comparator set
      level_o = LVL_ZERO;
      if (cmp_i.above_high) level_o = LVL_ONE;        // RQ8
      else if (cmp_i.above_mid) level_o = LVL_FLOAT;  // RQ8
      else if (cmp_i.above_low) level_o = LVL_RES;    // RQ8
   end
endmodule : strap_level_classifier
`default_nettype wire

// ==== verification/strap_board.sv ====
// board straps: resistor level to comparator code
`timescale 1ns/1ps
`default_nettype none
module strap_board #(parameter int N = 9) (
   input  wire logic [2*N-1:0] lvl_i,
   output logic      [3*N-1:0] cmp_o
);
   always_comb begin
      for (int i = 0; i < N; i++) begin
         cmp_o[3*i+:3] = {lvl_i[2*i+:2] == 2'h3, lvl_i[2*i+1], lvl_i[2*i+:2] != 2'h0};
      end
   end
endmodule : strap_board
`default_nettype wire

// ==== verification/four_level_strap_decoder_chk.sv ====
// port assertions for the strap decoder
`timescale 1ns/1ps
`default_nettype none
module four_level_strap_decoder_chk
   import strap_pkg::*;
(
   input wire logic       CLOCK_I,
   input wire logic       RST_B_I,
   input wire cmp_t       DETECT_THRESHOLD_I,
   input wire logic [3:0] SLAVE_ADDR_SELECT_I,
   input wire logic [7:0] SWING_CFG_REG_I,
   input wire logic [7:0] EQ_A_CODE_O,
   input wire logic [2:0] SWING_A_CODE_O,
   input wire logic [2:0] SWING_B_CODE_O,
   input wire logic [3:0] THRESHOLD_CODE_O,
   input wire logic [1:0] BUS_MODE_O,
   input wire logic [3:0] SLAVE_ADDR_O,
   input wire logic       CODES_VALID_O
);
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RST_B_I);
   logic [1:0] thr_now;
   logic [2:0] cfg_swing;
   logic       swing_one_code;
   always_comb begin
      thr_now = THR_ZERO;
      if (DETECT_THRESHOLD_I.above_high) thr_now = THR_ONE;
      else if (DETECT_THRESHOLD_I.above_mid) thr_now = THR_FLOAT;
      else if (DETECT_THRESHOLD_I.above_low) thr_now = THR_RES;
   end
   assign cfg_swing      = SWING_CFG_REG_I[SWING_REG_MSB:SWING_REG_LSB];
   // only a strap at one yields these channel B swing codes
   assign swing_one_code = (SWING_B_CODE_O == SWING_ONE_LO) || (SWING_B_CODE_O == SWING_ONE_HI);
   sequence boot_s; !CODES_VALID_O [*3] ##1 CODES_VALID_O; endsequence
   sequence settled_s; CODES_VALID_O && $past(CODES_VALID_O); endsequence
   boot_time_a: assert property ($rose(RST_B_I) |-> boot_s)
      else $error("valid not on third edge");
   valid_held_a: assert property (CODES_VALID_O |=> CODES_VALID_O)
      else $error("valid dropped");
   codes_held_a: assert property ($past(CODES_VALID_O) |-> $stable(EQ_A_CODE_O) && $stable(BUS_MODE_O))
      else $error("codes moved after sampling");
   thr_pair_a: assert property (THRESHOLD_CODE_O[3:2] == THRESHOLD_CODE_O[1:0])
      else $error("threshold fields differ");
   thr_decode_a: assert property ($rose(CODES_VALID_O) |-> THRESHOLD_CODE_O[1:0] == $past(thr_now))
      else $error("threshold code not from strap");
   pin_swing_a: assert property (CODES_VALID_O && BUS_MODE_O == 2'h0 |-> SWING_A_CODE_O == SWING_MIN)
      else $error("pin mode swing not minimum");
   bus_swing_a: assert property (CODES_VALID_O && BUS_MODE_O != 2'h0 |=> SWING_A_CODE_O == $past(cfg_swing))
      else $error("bus mode swing not from byte");
   addr_zero_a: assert property (settled_s ##0 (BUS_MODE_O != 2'h0 && swing_one_code) |-> SLAVE_ADDR_O == 4'h0)
      else $error("address not forced");
   addr_pass_a: assert property (settled_s ##0 BUS_MODE_O == 2'h0 |-> SLAVE_ADDR_O == $past(SLAVE_ADDR_SELECT_I))
      else $error("address not passed");
endmodule : four_level_strap_decoder_chk
bind four_level_strap_decoder four_level_strap_decoder_chk chk (.*);
`default_nettype wire

// ==== verification/four_level_strap_decoder_tb.sv ====
// self-checking bench for the strap decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
   $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module four_level_strap_decoder_tb;
   import strap_pkg::*;
   localparam logic [1:0] THR [4] = '{THR_ZERO, THR_RES, THR_FLOAT, THR_ONE};
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [17:0] lv = '0;
   logic [26:0] cmp;
   logic [3:0]  addr = '0;
   logic [7:0]  cfg = '0;
   logic [7:0]  eq_a, eq_b;
   logic [2:0]  dem_a, dem_b, sw_a, sw_b;
   logic [3:0]  thr, addr_o;
   logic [1:0]  mode;
   logic        valid;
   logic [17:0] lv_s;
   logic [30:0] held;
   int          num_errors = 0;
   int          tests_run = 0;
   always #25 clk = ~clk;
   strap_board #(.N(9)) board (.lvl_i(lv), .cmp_o(cmp));
   four_level_strap_decoder uut (.CLOCK_I(clk), .RST_B_I(rst_b), .EQ_A_HIGH_I(cmp[2:0]), .EQ_A_LOW_I(cmp[5:3]),
      .EQ_B_HIGH_I(cmp[8:6]), .EQ_B_LOW_I(cmp[11:9]), .DEEMPH_A_I(cmp[14:12]), .DEEMPH_B_I(cmp[17:15]),
      .SWING_SELECT_I(cmp[20:18]), .DETECT_THRESHOLD_I(cmp[23:21]), .BUS_ENABLE_I(cmp[26:24]),
      .SLAVE_ADDR_SELECT_I(addr), .SWING_CFG_REG_I(cfg), .EQ_A_CODE_O(eq_a), .EQ_B_CODE_O(eq_b),
      .DEEMPH_A_CODE_O(dem_a), .DEEMPH_B_CODE_O(dem_b), .SWING_A_CODE_O(sw_a), .SWING_B_CODE_O(sw_b),
      .THRESHOLD_CODE_O(thr), .BUS_MODE_O(mode), .SLAVE_ADDR_O(addr_o), .CODES_VALID_O(valid));
   function automatic logic [2:0] swing_exp(logic [1:0] s, logic [1:0] d);
      return s == 2'h0 ? 3'h0 : s == 2'h2 ? 3'h3 : s == 2'h1 ? 3'h5 : d[0] ? 3'h6 : 3'h4;
   endfunction : swing_exp
   function automatic logic [2:0] dem_exp(logic [1:0] s, logic [1:0] d);
      if (s == 2'h3) return d == 2'h0 ? 3'h0 : d == 2'h3 ? 3'h2 : 3'h1;
      return d == 2'h0 ? 3'h0 : d == 2'h1 ? 3'h3 : d == 2'h2 ? 3'h2 : 3'h5;
   endfunction : dem_exp
   task automatic results;
      $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : results
   initial begin
      void'($urandom(32'hAF9A));
      repeat (2) @(negedge clk);
      for (int i = 0; i < 48; i++) begin
         // first sixteen sweep every level pair of each equalizer pair and of swing with each de-emphasis strap, the rest random
         rst_b = 1'b0;
         lv = i < 16 ? {2'(i), 2'(i), 2'(i >> 2), 2'(i + 1), 2'(i), 2'(15 - i), 2'((15 - i) >> 2), 2'(i), 2'(i >> 2)}
                     : 18'($urandom);
         cfg = 8'($urandom);
         addr = 4'($urandom);
         repeat (2) @(negedge clk);
         rst_b = 1'b1;
         for (int w = 0; valid !== 1'b1; w++) begin
            if (w == 8) begin
               num_errors++;
               results();
            end
            @(negedge clk);
         end
         @(negedge clk);
         `CHK(eq_a, (EQ_TABLE[{lv[1:0], lv[3:2]}]))
         `CHK(eq_b, (EQ_TABLE[{lv[5:4], lv[7:6]}]))
         `CHK(dem_a, dem_exp(lv[13:12], lv[9:8]))
         `CHK(dem_b, dem_exp(lv[13:12], lv[11:10]))
         `CHK(sw_b, swing_exp(lv[13:12], lv[11:10]))
         `CHK(sw_a, lv[17:16] == 2'h0 ? SWING_MIN : cfg[4:2])
         `CHK(thr, {2{THR[lv[15:14]]}})
         `CHK(mode, lv[17:16])
         `CHK(addr_o, lv[17:16] != 2'h0 && lv[13:12] == 2'h3 ? 4'h0 : addr)
         // strap moves after sampling are refused; config byte and address pins stay live
         held = {eq_a, eq_b, dem_a, dem_b, sw_b, thr, mode};
         lv_s = lv;
         lv = 18'($urandom);
         cfg = 8'($urandom);
         addr = 4'($urandom);
         repeat (2) @(negedge clk);
         `CHK(({eq_a, eq_b, dem_a, dem_b, sw_b, thr, mode}), held)
         `CHK(sw_a, (lv_s[17:16] == 2'h0 ? SWING_MIN : cfg[4:2]))
         `CHK(addr_o, (lv_s[17:16] != 2'h0 && lv_s[13:12] == 2'h3 ? 4'h0 : addr))
         $display("test %0d done", i);
      end
      results();
   end
endmodule : four_level_strap_decoder_tb
`default_nettype wire
